// [hw/bccp_bcd_inc.v]
`timescale 1ns/100ps
// One BCD field with wrap to a low value at a limit
module bccp_bcd_inc
(
   input  wire [7:0] i_val,
   input  wire [7:0] i_max,
   input  wire [7:0] i_min,
   output wire [7:0] o_val,
   output wire       o_carry
);
   wire [3:0] lo_nxt;
   wire [3:0] hi_nxt;
   assign o_carry = (i_val >= i_max);
   assign lo_nxt  = (i_val[3:0] == 4'h9) ? 4'h0 : i_val[3:0] + 4'h1;
   assign hi_nxt  = (i_val[3:0] == 4'h9) ? i_val[7:4] + 4'h1 : i_val[7:4];
   assign o_val   = o_carry ? i_min : {hi_nxt, lo_nxt};
endmodule // bccp_bcd_inc

// [hw/bccp_por.v]
`timescale 1ns/100ps
`include "bccp_regs.vh"
// Power-on reset stretcher, clocked by the system clock only
module bccp_por
(
   input  wire i_clock,
   input  wire i_rst_n,
   input  wire i_fail,
   input  wire i_tick,
   output reg  o_rst_oe
);
   reg [15:0] cnt_r;
   always @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r    <= 16'h0000;
         o_rst_oe <= 1'b1;
      end
      else if (i_fail)
      begin
         cnt_r    <= 16'h0000;
         o_rst_oe <= 1'b1;
      end
      else if (o_rst_oe && i_tick)
      begin
         if (cnt_r == `BCCP_REC_TICKS - 16'h0001)
            o_rst_oe <= 1'b0;
         cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule // bccp_por

// [hw/bccp_regs.vh]
`ifndef BCCP_REGS_VH
`define BCCP_REGS_VH
// Register offsets on the byte port
`define BCCP_A_SEC        5'h00
`define BCCP_A_MIN        5'h01
`define BCCP_A_HOUR       5'h02
`define BCCP_A_DAY        5'h03
`define BCCP_A_DATE       5'h04
`define BCCP_A_MONTH      5'h05
`define BCCP_A_YEAR       5'h06
`define BCCP_A_CENT       5'h07
`define BCCP_A_ALM_SEC    5'h08
`define BCCP_A_ALM_MIN    5'h09
`define BCCP_A_ALM_HOUR   5'h0A
`define BCCP_A_ALM_DAY    5'h0B
`define BCCP_A_CTRL_A     5'h0E
`define BCCP_A_CTRL_B     5'h0F
// Control and month field positions
`define BCCP_B_HOLD_REL   7
`define BCCP_B_TIE        3
`define BCCP_B_KIE        2
`define BCCP_A_PAB        4
`define BCCP_A_TDF        3
`define BCCP_A_KSF        2
`define BCCP_A_IRQF       0
`define BCCP_M_EOSC_N     7
// Reset values
`define BCCP_CTRL_B_RST   8'h80
`define BCCP_DAY_RST      8'h01
`define BCCP_DATE_RST     8'h01
`define BCCP_MONTH_RST    8'h01
// Timing: oscillator 32768 Hz, seen as a tick pulse
`define BCCP_OSC_PER_SEC  15'h7FFF
`define BCCP_REC_TICKS    16'h1000
`endif

// [hw/bccp_rtc.v]
`timescale 1ns/100ps
`include "bccp_regs.vh"
// What this block does
// - Month end and leap February rollover
// - Internal copy advances while running, except a second that falls in the load cycle
// - Host can freeze and resume visible copy
// - Power fail deselects regardless of select
// - Alarm or key raises interrupt output
// - Key asserts power request; alarm does not
// - Read when select and drive low
// - Drive bus only during reads
// - Read data follows address
// - Write when select and strobe active
// - Write strobe stops read drive
// - Below trip, deselect bus, float data bus and interrupt
// - Oscillator enabled at power up
// - Reset held low through recovery period
// - Reset recovery counts oscillator ticks
// - Packed BCD, 24-hour hours
// - Day of week steps at midnight
// - Frozen visible copy while bit clear
// - Setting bit loads host values
module bccp_rtc
(
   input  wire       i_clock,
   input  wire       i_rst_n,
   input  wire       i_osc_32k,
   input  wire       i_powerfail_trip,
   input  wire       i_chip_sel_n,
   input  wire       i_out_drive_n,
   input  wire       i_write_n,
   input  wire [4:0] i_addr_in,
   input  wire [7:0] i_data_bus,
   input  wire       i_wake_key_in_n,
   output reg  [7:0] o_data_bus,
   output reg        o_data_bus_oe,
   output reg        o_irq_oe,
   output reg        o_power_request_n,
   output reg        o_square_wave_out,
   output reg        o_reset_oe
);
   // Two-stage synchronisers for pins
   reg [1:0] osc_s_r, fail_s_r, cs_s_r, oe_s_r, we_s_r, key_s_r;
   reg [4:0] addr_s1_r, addr_s2_r;
   reg [7:0] din_s1_r, din_s2_r;
   reg       osc_d_r, key_d_r, wr_d_r;

   wire fail    = fail_s_r[1];
   wire tick    = osc_s_r[1] & ~osc_d_r;
   wire key_hit = key_d_r & ~key_s_r[1];
   wire sel     = ~cs_s_r[1] & ~fail;
   wire wr_act  = sel & ~we_s_r[1];
   wire rd_act  = sel & ~oe_s_r[1] & we_s_r[1];
   wire wr_end  = wr_d_r & ~wr_act;

   always @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         osc_s_r   <= 2'h0;
         fail_s_r  <= 2'h3;
         cs_s_r    <= 2'h3;
         oe_s_r    <= 2'h3;
         we_s_r    <= 2'h3;
         key_s_r   <= 2'h3;
         addr_s1_r <= 5'h00;
         addr_s2_r <= 5'h00;
         din_s1_r  <= 8'h00;
         din_s2_r  <= 8'h00;
         osc_d_r   <= 1'b0;
         key_d_r   <= 1'b1;
         wr_d_r    <= 1'b0;
      end
      else
      begin
         osc_s_r   <= {osc_s_r[0], i_osc_32k};
         fail_s_r  <= {fail_s_r[0], i_powerfail_trip};
         cs_s_r    <= {cs_s_r[0], i_chip_sel_n};
         oe_s_r    <= {oe_s_r[0], i_out_drive_n};
         we_s_r    <= {we_s_r[0], i_write_n};
         key_s_r   <= {key_s_r[0], i_wake_key_in_n};
         addr_s1_r <= i_addr_in;
         addr_s2_r <= addr_s1_r;
         din_s1_r  <= i_data_bus;
         din_s2_r  <= din_s1_r;
         osc_d_r   <= osc_s_r[1];
         key_d_r   <= key_s_r[1];
         wr_d_r    <= wr_act;
      end
   end

   // Calendar state: internal and visible copies
   reg [7:0] in_r [0:7];
   reg [7:0] vis_r [0:7];
   reg [7:0] alm_r [0:3];
   reg [7:0] ctrl_a_r, ctrl_b_r;
   reg       eosc_n_r;
   reg       load_r;
   reg [7:0] dirty_r;
   reg [14:0] div_r;
   integer   k;

   function [7:0] bcccp_month_days;
      input [7:0] month;
      input [7:0] year;
      input [7:0] cent;
      reg         leap;
      begin
         leap = ~year[4] ? (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8)
                         : (year[3:0] == 4'h2 || year[3:0] == 4'h6);
         if (year == 8'h00)
            leap = (cent[4] ? (cent[3:0] == 4'h2 || cent[3:0] == 4'h6)
                            : (cent[3:0] == 4'h0 || cent[3:0] == 4'h4 || cent[3:0] == 4'h8));
         case (month)
            8'h02:   bcccp_month_days = leap ? 8'h29 : 8'h28;
            8'h04,
            8'h06,
            8'h09,
            8'h11:   bcccp_month_days = 8'h30;
            default: bcccp_month_days = 8'h31;
         endcase
      end
   endfunction

   wire [7:0] mlim = bcccp_month_days({3'h0, in_r[5][4:0]}, in_r[6], in_r[7]);
   wire [7:0] sec_n, min_n, hr_n, day_n, dt_n, mo_n, yr_n, ce_n;
   wire       c_sec, c_min, c_hr, c_day_u, c_dt, c_mo, c_yr, c_ce_u;

   bccp_bcd_inc u_sec
   (
      .i_val   (in_r[0]),
      .i_max   (8'h59),
      .i_min   (8'h00),
      .o_val   (sec_n),
      .o_carry (c_sec)
   );
   bccp_bcd_inc u_min
   (
      .i_val   (in_r[1]),
      .i_max   (8'h59),
      .i_min   (8'h00),
      .o_val   (min_n),
      .o_carry (c_min)
   );
   bccp_bcd_inc u_hr
   (
      .i_val   (in_r[2]),
      .i_max   (8'h23),
      .i_min   (8'h00),
      .o_val   (hr_n),
      .o_carry (c_hr)
   );
   bccp_bcd_inc u_day
   (
      .i_val   (in_r[3]),
      .i_max   (8'h07),
      .i_min   (8'h01),
      .o_val   (day_n),
      .o_carry (c_day_u)
   );
   bccp_bcd_inc u_dt
   (
      .i_val   (in_r[4]),
      .i_max   (mlim),
      .i_min   (8'h01),
      .o_val   (dt_n),
      .o_carry (c_dt)
   );
   bccp_bcd_inc u_mo
   (
      .i_val   ({3'h0, in_r[5][4:0]}),
      .i_max   (8'h12),
      .i_min   (8'h01),
      .o_val   (mo_n),
      .o_carry (c_mo)
   );
   bccp_bcd_inc u_yr
   (
      .i_val   (in_r[6]),
      .i_max   (8'h99),
      .i_min   (8'h00),
      .o_val   (yr_n),
      .o_carry (c_yr)
   );
   bccp_bcd_inc u_ce
   (
      .i_val   (in_r[7]),
      .i_max   (8'h39),
      .i_min   (8'h00),
      .o_val   (ce_n),
      .o_carry (c_ce_u)
   );

   wire sec_tick = tick && (div_r == `BCCP_OSC_PER_SEC) && !eosc_n_r;
   wire t1 = c_sec;
   wire t2 = t1 & c_min;
   wire t3 = t2 & c_hr;
   wire t4 = t3 & c_dt;
   wire t5 = t4 & c_mo;
   wire t6 = t5 & c_yr;
   wire alarm_hit = (alm_r[0] == in_r[0]) && (alm_r[1] == in_r[1])
                    && (alm_r[2] == in_r[2]);

   always @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         for (k = 0; k < 8; k = k + 1)
         begin
            in_r[k]  <= 8'h00;
            vis_r[k] <= 8'h00;
         end
         for (k = 0; k < 4; k = k + 1)
            alm_r[k] <= 8'h00;
         in_r[3]  <= `BCCP_DAY_RST;
         in_r[4]  <= `BCCP_DATE_RST;
         in_r[5]  <= `BCCP_MONTH_RST;
         ctrl_a_r <= 8'h00;
         ctrl_b_r <= `BCCP_CTRL_B_RST;
         eosc_n_r <= 1'b0;
         load_r   <= 1'b0;
         dirty_r  <= 8'h00;
         div_r    <= 15'h0000;
      end
      else
      begin
         if (tick)
            div_r <= div_r + 15'h0001;
         if (load_r)
         begin
            // Only host-written fields; the rest keep their count
            for (k = 0; k < 8; k = k + 1)
               if (dirty_r[k])
                  in_r[k] <= vis_r[k];
            load_r  <= 1'b0;
            dirty_r <= 8'h00;
         end
         else if (sec_tick)
         begin
            in_r[0] <= sec_n;
            if (t1) in_r[1] <= min_n;
            if (t2) in_r[2] <= hr_n;
            if (t3) in_r[3] <= day_n;
            if (t3) in_r[4] <= dt_n;
            if (t4) in_r[5] <= {in_r[5][7:5], mo_n[4:0]};
            if (t5) in_r[6] <= yr_n;
            if (t6) in_r[7] <= ce_n;
         end
         else if (ctrl_b_r[`BCCP_B_HOLD_REL] && !wr_act)
         begin
            for (k = 0; k < 8; k = k + 1)
               vis_r[k] <= in_r[k];
            dirty_r <= 8'h00;
         end
         if (alarm_hit && sec_tick)
            ctrl_a_r[`BCCP_A_TDF] <= 1'b1;
         if (key_hit)
         begin
            ctrl_a_r[`BCCP_A_KSF] <= 1'b1;
            ctrl_a_r[`BCCP_A_PAB] <= 1'b1;
         end
         if (wr_end)
         begin
            case (addr_s2_r)
               `BCCP_A_SEC,
               `BCCP_A_MIN,
               `BCCP_A_HOUR,
               `BCCP_A_DAY,
               `BCCP_A_DATE,
               `BCCP_A_YEAR,
               `BCCP_A_CENT:
               begin
                  vis_r[addr_s2_r[2:0]]   <= din_s2_r;
                  dirty_r[addr_s2_r[2:0]] <= 1'b1;
               end
               `BCCP_A_MONTH:
               begin
                  vis_r[5]   <= din_s2_r;
                  dirty_r[5] <= 1'b1;
                  eosc_n_r <= din_s2_r[`BCCP_M_EOSC_N];
               end
               `BCCP_A_ALM_SEC,
               `BCCP_A_ALM_MIN,
               `BCCP_A_ALM_HOUR,
               `BCCP_A_ALM_DAY: alm_r[addr_s2_r[1:0]] <= din_s2_r;
               `BCCP_A_CTRL_A:
               begin
                  // Writing zero releases power request; a fresh event wins
                  if (!din_s2_r[`BCCP_A_PAB] && !key_hit)
                     ctrl_a_r[`BCCP_A_PAB] <= 1'b0;
                  if (!din_s2_r[`BCCP_A_TDF] && !(alarm_hit && sec_tick))
                     ctrl_a_r[`BCCP_A_TDF] <= 1'b0;
                  if (!din_s2_r[`BCCP_A_KSF] && !key_hit)
                     ctrl_a_r[`BCCP_A_KSF] <= 1'b0;
               end
               `BCCP_A_CTRL_B:
               begin
                  ctrl_b_r <= din_s2_r;
                  if (din_s2_r[`BCCP_B_HOLD_REL] && !ctrl_b_r[`BCCP_B_HOLD_REL])
                     load_r <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   wire irq_now = (ctrl_a_r[`BCCP_A_TDF] & ctrl_b_r[`BCCP_B_TIE])
                | (ctrl_a_r[`BCCP_A_KSF] & ctrl_b_r[`BCCP_B_KIE]);

   reg [7:0] rd_mux;
   always @*
   begin
      rd_mux = 8'h00;
      if (addr_s2_r <= `BCCP_A_CENT)
         rd_mux = vis_r[addr_s2_r[2:0]];
      else if (addr_s2_r >= `BCCP_A_ALM_SEC && addr_s2_r <= `BCCP_A_ALM_DAY)
         rd_mux = alm_r[addr_s2_r[1:0]];
      else if (addr_s2_r == `BCCP_A_CTRL_A)
         rd_mux = {ctrl_a_r[7:1], irq_now};
      else if (addr_s2_r == `BCCP_A_CTRL_B)
         rd_mux = ctrl_b_r;
   end

   wire por_oe;
   bccp_por u_por
   (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_fail   (fail),
      .i_tick   (tick),
      .o_rst_oe (por_oe)
   );

   always @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_data_bus        <= 8'h00;
         o_data_bus_oe     <= 1'b0;
         o_irq_oe          <= 1'b0;
         o_power_request_n <= 1'b1;
         o_square_wave_out <= 1'b0;
         o_reset_oe        <= 1'b1;
      end
      else
      begin
         o_data_bus        <= rd_mux;
         o_data_bus_oe     <= rd_act;
         o_irq_oe          <= irq_now & ~fail;
         o_power_request_n <= ~ctrl_a_r[`BCCP_A_PAB];
         o_square_wave_out <= osc_s_r[1];
         o_reset_oe        <= por_oe;
      end
   end
endmodule // bccp_rtc

// [tb/bccp_host_model.sv]
`timescale 1ns/100ps
module bccp_host_model
(
   input  wire       i_clock,
   input  wire [7:0] i_data_bus,
   input  wire       i_data_bus_oe,
   output reg        o_chip_sel_n,
   output reg        o_out_drive_n,
   output reg        o_write_n,
   output reg  [4:0] o_addr_in,
   output reg  [7:0] o_data_bus
);
   initial
   begin
      o_chip_sel_n  = 1'b1;
      o_out_drive_n = 1'b1;
      o_write_n     = 1'b1;
      o_addr_in     = 5'h00;
      o_data_bus    = 8'h00;
   end
   task tk(input integer n);
      begin
         repeat (n) @(posedge i_clock);
         #1;
      end
   endtask
   task set_pins(input logic cs, input logic od, input logic we, input logic [4:0] a);
      begin
         o_chip_sel_n  = cs;
         o_out_drive_n = od;
         o_write_n     = we;
         o_addr_in     = a;
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      begin
         tk(1);
         set_pins(1'b0, 1'b1, 1'b0, a);
         o_data_bus = d;
         tk(5);
         set_pins(1'b1, 1'b1, 1'b1, a);
         tk(5);
         o_data_bus = ~d;
         tk(6);
      end
   endtask
   task rd(input logic [4:0] a, output logic [7:0] d);
      integer n;
      begin
         tk(1);
         set_pins(1'b0, 1'b0, 1'b1, a);
         n = 0;
         while (i_data_bus_oe !== 1'b1 && n < 12)
         begin
            tk(1);
            n = n + 1;
         end
         tk(2);
         d = (i_data_bus_oe === 1'b1) ? i_data_bus : 8'hZZ;
         set_pins(1'b1, 1'b1, 1'b1, a);
         tk(6);
      end
   endtask
endmodule // bccp_host_model

// [tb/bccp_rtc_checker.sv]
`timescale 1ns/100ps
`include "bccp_regs.vh"
module bccp_rtc_checker
(
   input wire       i_clock,
   input wire       i_rst_n,
   input wire       i_osc_32k,
   input wire       i_powerfail_trip,
   input wire       i_chip_sel_n,
   input wire       i_out_drive_n,
   input wire       i_write_n,
   input wire [4:0] i_addr_in,
   input wire [7:0] i_data_bus,
   input wire       i_wake_key_in_n,
   input wire [7:0] o_data_bus,
   input wire       o_data_bus_oe,
   input wire       o_irq_oe,
   input wire       o_power_request_n,
   input wire       o_square_wave_out,
   input wire       o_reset_oe
);
   localparam int REC_LO = `BCCP_REC_TICKS - 2;
   logic       rd_req;
   logic [3:0] on_cnt_r;
   logic [3:0] off_cnt_r;
   logic       osc_d_r;
   int         tick_cnt_r;
   assign rd_req = !i_chip_sel_n && !i_out_drive_n && i_write_n && !i_powerfail_trip;
   always @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         on_cnt_r   <= 4'h0;
         off_cnt_r  <= 4'hF;
         osc_d_r    <= 1'b0;
         tick_cnt_r <= 0;
      end
      else
      begin
         on_cnt_r   <= rd_req ? on_cnt_r + {3'h0, on_cnt_r != 4'hF} : 4'h0;
         off_cnt_r  <= rd_req ? 4'h0 : off_cnt_r + {3'h0, off_cnt_r != 4'hF};
         osc_d_r    <= i_osc_32k;
         tick_cnt_r <= i_powerfail_trip ? 0 : tick_cnt_r + int'(i_osc_32k && !osc_d_r);
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   AST_OE_ONLY_READ: assert property (o_data_bus_oe |-> off_cnt_r < 4'h6)
      else $error("bus driven without a read");
   AST_OE_APPEARS: assert property (on_cnt_r == 4'h8 |-> o_data_bus_oe)
      else $error("read not answered");
   AST_WE_STOPS: assert property ($fell(i_write_n) && !i_chip_sel_n && !i_out_drive_n
      |-> ##[1:6] !o_data_bus_oe) else $error("write strobe did not stop drive");
   AST_PF_DESELECT: assert property (i_powerfail_trip[*6] |-> !o_data_bus_oe)
      else $error("bus driven in power fail");
   AST_PF_RESET: assert property ($rose(i_powerfail_trip) |-> ##[1:6] o_reset_oe)
      else $error("reset not pulled on power fail");
   AST_RESET_HOLD: assert property ($fell(o_reset_oe) |-> tick_cnt_r >= REC_LO)
      else $error("reset released early");
   AST_RESET_STAYS: assert property (o_reset_oe && tick_cnt_r < REC_LO - 8 |=> o_reset_oe)
      else $error("reset dropped in recovery");
   AST_SQW: assert property ($rose(o_square_wave_out) |-> $past(i_osc_32k, 2)
      || $past(i_osc_32k, 3) || $past(i_osc_32k, 4)) else $error("square wave not osc");
   cover property (rd_req && o_data_bus_oe);
   cover property ($fell(o_reset_oe));
   cover property ($rose(i_powerfail_trip));
   cover property ($fell(o_power_request_n));
endmodule // bccp_rtc_checker
bind bccp_rtc bccp_rtc_checker bccp_rtc_checker_i (.i_clock(i_clock), .i_rst_n(i_rst_n),
   .i_osc_32k(i_osc_32k), .i_powerfail_trip(i_powerfail_trip), .i_chip_sel_n(i_chip_sel_n),
   .i_out_drive_n(i_out_drive_n), .i_write_n(i_write_n), .i_addr_in(i_addr_in),
   .i_data_bus(i_data_bus), .i_wake_key_in_n(i_wake_key_in_n), .o_data_bus(o_data_bus),
   .o_data_bus_oe(o_data_bus_oe), .o_irq_oe(o_irq_oe), .o_power_request_n(o_power_request_n),
   .o_square_wave_out(o_square_wave_out), .o_reset_oe(o_reset_oe));

// [tb/tb_top.sv]
`timescale 1ns/100ps
`include "bccp_regs.vh"
module tb_top;
   localparam integer REC = `BCCP_REC_TICKS;
   localparam integer SEC = `BCCP_OSC_PER_SEC + 1;
   logic       i_clock = 1'b0;
   logic       i_rst_n = 1'b0;
   logic       i_osc_32k = 1'b0;
   logic       i_powerfail_trip = 1'b0;
   logic       i_wake_key_in_n = 1'b1;
   wire        cs_n;
   wire        od_n;
   wire        we_n;
   wire  [4:0] addr;
   wire  [7:0] wdata;
   wire  [7:0] rdata;
   wire        rd_oe;
   wire        o_reset_oe;
   wire        o_irq_oe;
   wire        o_power_request_n;
   wire        o_square_wave_out;
   integer     errors = 0;
   integer     checked = 0;
   integer     osc_half = 1;
   integer     ticks = 0;
   integer     i;
   logic [7:0] v;
   logic       sq;
   logic [7:0] rv [0:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
   logic [7:0] tv [0:7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h29, 8'h02, 8'h24, 8'h20};
   // One second after tv: leap February ends, day wraps to 1
   logic [7:0] nv [0:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h24, 8'h20};

   always #10 i_clock = ~i_clock;
   always
   begin
      repeat (osc_half) @(posedge i_clock);
      #1;
      i_osc_32k = ~i_osc_32k;
      if (i_osc_32k) ticks = ticks + 1;
   end

   bccp_host_model bccp_host_model_i (.i_clock(i_clock), .i_data_bus(rdata),
      .i_data_bus_oe(rd_oe), .o_chip_sel_n(cs_n), .o_out_drive_n(od_n), .o_write_n(we_n),
      .o_addr_in(addr), .o_data_bus(wdata));
   bccp_rtc bccp_rtc_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_osc_32k(i_osc_32k),
      .i_powerfail_trip(i_powerfail_trip), .i_chip_sel_n(cs_n), .i_out_drive_n(od_n),
      .i_write_n(we_n), .i_addr_in(addr), .i_data_bus(wdata),
      .i_wake_key_in_n(i_wake_key_in_n), .o_data_bus(rdata), .o_data_bus_oe(rd_oe),
      .o_irq_oe(o_irq_oe), .o_power_request_n(o_power_request_n),
      .o_square_wave_out(o_square_wave_out), .o_reset_oe(o_reset_oe));

   task chk(input logic [7:0] got, input logic [7:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("errors=%0d checked=%0d", errors, checked);
         if (errors == 0 && checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task t_recovery;
      begin
         chk({7'h00, o_reset_oe}, 8'h01);
         wait (ticks == REC - 16);
         bccp_host_model_i.tk(1);
         chk({7'h00, o_reset_oe}, 8'h01);
         while (o_reset_oe === 1'b1 && ticks < REC + 16) bccp_host_model_i.tk(1);
         chk({7'h00, o_reset_oe}, 8'h00);
      end
   endtask
   task t_reset_vals;
      begin
         for (i = 0; i < 8; i = i + 1)
         begin
            bccp_host_model_i.rd(i[4:0], v);
            chk(v, rv[i]);
         end
         bccp_host_model_i.rd(`BCCP_A_CTRL_B, v);
         chk(v, `BCCP_CTRL_B_RST);
      end
   endtask
   task t_read_modes;
      begin
         bccp_host_model_i.set_pins(1'b0, 1'b1, 1'b1, `BCCP_A_CTRL_B);
         bccp_host_model_i.tk(8);
         chk({7'h00, rd_oe}, 8'h00);
         bccp_host_model_i.set_pins(1'b0, 1'b0, 1'b1, `BCCP_A_DAY);
         bccp_host_model_i.tk(8);
         chk(rdata, 8'h01);
         bccp_host_model_i.set_pins(1'b0, 1'b0, 1'b1, `BCCP_A_CTRL_B);
         bccp_host_model_i.tk(8);
         chk(rdata, 8'h80);
         bccp_host_model_i.o_data_bus = 8'h00;
         bccp_host_model_i.set_pins(1'b0, 1'b0, 1'b0, `BCCP_A_CTRL_B);
         bccp_host_model_i.tk(8);
         chk({7'h00, rd_oe}, 8'h00);
         bccp_host_model_i.set_pins(1'b1, 1'b1, 1'b1, `BCCP_A_CTRL_B);
         bccp_host_model_i.tk(8);
         bccp_host_model_i.rd(`BCCP_A_CTRL_B, v);
         chk(v, 8'h00);
      end
   endtask
   task t_unmapped;
      begin
         bccp_host_model_i.wr(5'h1F, 8'hA5);
         bccp_host_model_i.rd(5'h1F, v);
         chk(v, 8'h00);
      end
   endtask
   task t_set_time;
      begin
         bccp_host_model_i.wr(`BCCP_A_CTRL_B, 8'h00);
         for (i = 0; i < 8; i = i + 1) bccp_host_model_i.wr(i[4:0], tv[i]);
         for (i = 0; i < 8; i = i + 1)
         begin
            bccp_host_model_i.rd(i[4:0], v);
            chk(v, tv[i]);
         end
         bccp_host_model_i.wr(`BCCP_A_CTRL_B, 8'h80);
         for (i = 0; i < 8; i = i + 1)
         begin
            bccp_host_model_i.rd(i[4:0], v);
            chk(v, tv[i]);
         end
      end
   endtask
   task t_powerfail;
      begin
         i_powerfail_trip = 1'b1;
         bccp_host_model_i.tk(8);
         chk({7'h00, o_reset_oe}, 8'h01);
         sq = o_square_wave_out;
         bccp_host_model_i.tk(1);
         chk({7'h00, o_square_wave_out}, {7'h00, ~sq});
         bccp_host_model_i.wr(`BCCP_A_SEC, 8'h11);
         bccp_host_model_i.rd(`BCCP_A_SEC, v);
         chk(v, 8'hZZ);
         i_powerfail_trip = 1'b0;
         bccp_host_model_i.tk(8);
         bccp_host_model_i.rd(`BCCP_A_SEC, v);
         chk(v, tv[0]);
         chk({7'h00, o_reset_oe}, 8'h01);
      end
   endtask
   task t_wake_key;
      begin
         bccp_host_model_i.wr(`BCCP_A_CTRL_B, 8'h84);
         chk({7'h00, o_power_request_n}, 8'h01);
         i_wake_key_in_n = 1'b0;
         bccp_host_model_i.tk(8);
         chk({7'h00, o_power_request_n}, 8'h00);
         chk({7'h00, o_irq_oe}, 8'h01);
         i_wake_key_in_n = 1'b1;
         bccp_host_model_i.rd(`BCCP_A_CTRL_A, v);
         chk(v, 8'h15);
         bccp_host_model_i.wr(`BCCP_A_CTRL_A, 8'h00);
         chk({7'h00, o_power_request_n}, 8'h01);
         chk({7'h00, o_irq_oe}, 8'h00);
      end
   endtask
   task t_rollover;
      begin
         bccp_host_model_i.wr(`BCCP_A_CTRL_B, 8'h00);
         wait (ticks == SEC + 32);
         bccp_host_model_i.rd(`BCCP_A_SEC, v);
         chk(v, tv[0]);
         bccp_host_model_i.wr(`BCCP_A_CTRL_B, 8'h80);
         for (i = 0; i < 8; i = i + 1)
         begin
            bccp_host_model_i.rd(i[4:0], v);
            chk(v, nv[i]);
         end
      end
   endtask

   initial
   begin
      #1_800_000;
      errors = errors + 1;
      wrap_up;
   end
   initial
   begin
      repeat (12) @(posedge i_clock);
      #1;
      i_rst_n = 1'b1;
      t_recovery;
      t_reset_vals;
      t_read_modes;
      t_unmapped;
      t_set_time;
      t_powerfail;
      t_wake_key;
      t_rollover;
      wrap_up;
   end
endmodule // tb_top
